// File: rtl/txcf_core.sv
// Notes on behaviour
// - pcs-side fifo stays in phase compensation
// - phase mode absorbs write/read clock offset
// - register mode bypasses the fifo storage
// - register mode: one output register stage
// - interlaken reads come from frame generator
// - basic mode: elastic, user-controlled reads
// - partially-full threshold programmable 0..31
// - partially-empty threshold programmable 0..31
// - full flag, write-clock synchronous
// - empty flag while no entries held
// - pfull flag once threshold reached
// - pempty flag at or below threshold, unregistered
//
// The address map and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module txcf_core
   import txcf_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [WB_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // user write side
   input wire txcf_word_s wr_word,
   input wire logic wr_en,
   // pcs read side
   input wire logic rd_en,
   input wire logic frame_rd,
   output txcf_word_s rd_word,
   output logic rd_valid,
   // flags and interrupt
   output txcf_flags_s flags,
   output logic irq
);

   // ----------------------------------------
   // functions
   // ----------------------------------------
   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      ptr_inc = p + PTR_ONE;
   endfunction : ptr_inc

   function automatic logic wb_lane(input logic [3:0] sel, input int lane);
      wb_lane = sel[lane];
   endfunction : wb_lane

   // ----------------------------------------
   // registers
   // ----------------------------------------
   txcf_mode_e mode;
   logic [THR_W-1:0] pfull_thr;
   logic [THR_W-1:0] pempty_thr;
   logic [IRQ_N-1:0] irq_stat;
   logic [IRQ_N-1:0] irq_mask;
   logic ack;

   txcf_word_s mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [CNT_W-1:0] count;
   txcf_word_s bypass_q;
   txcf_word_s out_q;
   logic out_v;
   logic pfull_q;
   logic full_q;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire logic bus_req = wb_cyc_i & wb_stb_i & ~ack;
   wire logic bus_wr = bus_req & wb_we_i;
   wire logic page1 = wb_adr_i[ADR_PAGE_BIT];
   wire logic [ADR_W-1:0] adr_lo = wb_adr_i[ADR_W-1:0];
   wire logic hit_ctrl = ~page1 & (adr_lo == ADR_CTRL);
   wire logic hit_thr = ~page1 & (adr_lo == ADR_THRESH);
   wire logic hit_status = ~page1 & (adr_lo == ADR_STATUS);
   wire logic hit_istat = ~page1 & (adr_lo == ADR_IRQ_STAT);
   wire logic hit_imask = page1 & (adr_lo == ADR_IRQ_MASK);
   wire logic hit_level = page1 & (adr_lo == ADR_LEVEL);
   wire logic lane0 = wb_lane(wb_sel_i, 0);
   wire logic lane1 = wb_lane(wb_sel_i, 1);

   // ----------------------------------------
   // fifo control
   // ----------------------------------------
   wire logic is_reg = (mode == TXCF_REGISTER);
   wire logic is_ilk = (mode == TXCF_INTERLAKEN);
   // phase mode fills on every valid word; basic and interlaken only on strobe
   wire logic wr_req = is_ilk ? wr_en : (mode == TXCF_BASIC ? wr_en : wr_word.valid);
   // interlaken drains only when the frame generator asks
   wire logic rd_req = is_ilk ? frame_rd : rd_en;
   wire logic fifo_full = (count == CNT_FULL);
   wire logic fifo_empty = (count == CNT_ZERO);
   wire logic do_wr = ~is_reg & wr_req & ~fifo_full;
   wire logic do_rd = ~is_reg & rd_req & ~fifo_empty;
   wire logic ovf_evt = ~is_reg & wr_req & fifo_full;
   wire logic udf_evt = ~is_reg & rd_req & fifo_empty;
   wire logic [CNT_W-1:0] cnt_inc = count + CNT_ONE;
   wire logic [CNT_W-1:0] cnt_dec = count - CNT_ONE;
   wire logic [CNT_W-1:0] next_count = (do_wr & ~do_rd) ? cnt_inc :
                                       (do_rd & ~do_wr) ? cnt_dec : count;
   wire logic next_pfull = (next_count >= {1'b0, pfull_thr});
   wire logic pempty_now = (count <= {1'b0, pempty_thr});
   wire logic rise_pfull = next_pfull & ~pfull_q;
   wire logic [IRQ_N-1:0] irq_evt = {pempty_now, rise_pfull, udf_evt, ovf_evt};

   // ----------------------------------------
   // storage and pointers
   // ----------------------------------------
   // the pcs-side fifo is a fixed phase-compensation stage outside this block
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= wr_word;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= CNT_ZERO;
      end else if (is_reg) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= CNT_ZERO;
      end else begin
         if (do_wr) wr_ptr <= ptr_inc(wr_ptr);
         if (do_rd) rd_ptr <= ptr_inc(rd_ptr);
         count <= next_count;
      end
   end

   // ----------------------------------------
   // output stage
   // ----------------------------------------
   // register mode relies on one shared clock and valid held high
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bypass_q <= '0;
      end else begin
         bypass_q <= wr_word;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         out_q <= '0;
         out_v <= 1'b0;
      end else begin
         out_v <= do_rd;
         if (do_rd) out_q <= mem[rd_ptr];
      end
   end

   assign rd_word = is_reg ? bypass_q : out_q;
   assign rd_valid = is_reg ? bypass_q.valid : out_v;

   // ----------------------------------------
   // flags
   // ----------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         full_q <= 1'b0;
         pfull_q <= 1'b0;
      end else begin
         full_q <= ~is_reg & (next_count == CNT_FULL);
         pfull_q <= ~is_reg & next_pfull;
      end
   end

   // empty and pempty follow the count directly; consumers must synchronise
   wire logic empty_out = is_reg ? 1'b1 : fifo_empty;
   wire logic pempty_out = is_reg ? 1'b1 : pempty_now;
   // one driver for the whole carrier, fields in declaration order
   assign flags = {full_q, empty_out, pfull_q, pempty_out};

   // ----------------------------------------
   // register file
   // ----------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode <= TXCF_PHASE;
         pfull_thr <= PFULL_RST;
         pempty_thr <= PEMPTY_RST;
         irq_mask <= '0;
      end else if (bus_wr) begin
         if (hit_ctrl & lane0) mode <= txcf_mode_e'(wb_dat_i[MODE_LSB +: 2]);
         if (hit_thr & lane0) pfull_thr <= wb_dat_i[PFULL_LSB +: THR_W];
         if (hit_thr & lane1) pempty_thr <= wb_dat_i[PEMPTY_LSB +: THR_W];
         if (hit_imask & lane0) irq_mask <= wb_dat_i[IRQ_N-1:0];
      end
   end

   // a new event wins over a write-one-to-clear in the same cycle
   wire logic [IRQ_N-1:0] w1c = (bus_wr & hit_istat & lane0) ? wb_dat_i[IRQ_N-1:0] : '0;
   wire logic [IRQ_N-1:0] next_irq_stat = (irq_stat & ~w1c) | irq_evt;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= next_irq_stat;
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // ----------------------------------------
   // read mux and ack
   // ----------------------------------------
   wire logic [31:0] rd_mux =
      hit_ctrl ? {30'h0, mode} :
      hit_thr ? {19'h0, pempty_thr, 3'h0, pfull_thr} :
      hit_status ? {28'h0, flags.full, flags.empty, flags.pfull, flags.pempty} :
      hit_istat ? {28'h0, irq_stat} :
      hit_imask ? {28'h0, irq_mask} :
      hit_level ? {26'h0, count} : 32'h0;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ack <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         ack <= bus_req;
         if (bus_req) wb_dat_o <= rd_mux;
      end
   end

   assign wb_ack_o = ack;

endmodule : txcf_core
`default_nettype wire

// File: pkg/txcf_pkg.sv
`default_nettype none
package txcf_pkg;
   // ----------------------------------------
   // datapath widths and fifo geometry
   // ----------------------------------------
   localparam int DATA_W = 64;
   localparam int CTRL_W = 8;
   localparam int DEPTH = 32;
   localparam int PTR_W = 5;
   localparam int CNT_W = 6;
   localparam int THR_W = 5;
   localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
   localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
   localparam logic [PTR_W-1:0] PTR_ONE = 5'h01;

   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam int ADR_W = 4;
   localparam logic [ADR_W-1:0] ADR_CTRL = 4'h0;
   localparam logic [ADR_W-1:0] ADR_THRESH = 4'h4;
   localparam logic [ADR_W-1:0] ADR_STATUS = 4'h8;
   localparam logic [ADR_W-1:0] ADR_IRQ_STAT = 4'hC;
   localparam logic [ADR_W-1:0] ADR_IRQ_MASK = 4'h0;
   localparam logic [ADR_W-1:0] ADR_LEVEL = 4'h4;
   localparam int ADR_PAGE_BIT = 4;
   localparam int WB_ADR_W = 5;

   // field positions
   localparam int MODE_LSB = 0;
   localparam int PFULL_LSB = 0;
   localparam int PEMPTY_LSB = 8;
   localparam int IRQ_N = 4;
   localparam int IRQ_OVF = 0;
   localparam int IRQ_UDF = 1;
   localparam int IRQ_PFULL = 2;
   localparam int IRQ_PEMPTY = 3;

   // reset values
   localparam logic [THR_W-1:0] PFULL_RST = 5'h18;
   localparam logic [THR_W-1:0] PEMPTY_RST = 5'h04;

   // ----------------------------------------
   // modes and carriers
   // ----------------------------------------
   typedef enum logic [1:0] {
      TXCF_PHASE = 2'b00,
      TXCF_REGISTER = 2'b01,
      TXCF_INTERLAKEN = 2'b10,
      TXCF_BASIC = 2'b11
   } txcf_mode_e;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [CTRL_W-1:0] ctrl;
      logic valid;
   } txcf_word_s;

   typedef struct packed {
      logic full;
      logic empty;
      logic pfull;
      logic pempty;
   } txcf_flags_s;
endpackage : txcf_pkg
`default_nettype wire

// File: dv/txcf_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module txcf_monitor
   import txcf_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // observed ports
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire txcf_word_s wr_word,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic frame_rd,
   input wire logic rd_valid,
   input wire txcf_flags_s flags
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // ----------------------------------------
   // sequences
   // ----------------------------------------
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_idle;
      flags.empty && !wr_en && !wr_word.valid;
   endsequence
   sequence s_full_quiet;
      flags.full && !rd_en && !frame_rd && !wb_cyc_i;
   endsequence
   // ----------------------------------------
   // properties
   // ----------------------------------------
   ack_follows_a: assert property (s_req |=> wb_ack_o) else $error("ack late");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   full_hold_a: assert property (s_full_quiet |=> flags.full) else $error("full lost");
   full_pfull_a: assert property (flags.full |-> flags.pfull) else $error("pfull low");
   empty_pempty_a: assert property (flags.empty |-> flags.pempty) else $error("pempty low");
   flags_exclusive_a: assert property (!(flags.full && flags.empty)) else $error("full and empty");
   idle_no_out_a: assert property (s_idle |=> !rd_valid) else $error("read from empty");
endmodule : txcf_monitor
bind txcf_core txcf_monitor u_mon (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wr_word(wr_word), .wr_en(wr_en),
   .rd_en(rd_en), .frame_rd(frame_rd), .rd_valid(rd_valid), .flags(flags));
`default_nettype wire

// File: dv/txcf_partner.sv
`timescale 1ns/1ps
`default_nettype none
module txcf_partner
   import txcf_pkg::*;
(
   // clock shared with the read side
   input wire logic clk,
   // user write side
   output txcf_word_s wr_word,
   output logic wr_en
);
   initial begin
      wr_word = '0;
      wr_en = 1'b0;
   end
   task automatic send(input txcf_word_s w, input logic gate);
      @(posedge clk);
      wr_word <= w;
      wr_en <= gate;
   endtask : send
   // released lines flip so stale data cannot pass for fresh
   task automatic stop();
      @(posedge clk);
      wr_word <= {~wr_word.data, ~wr_word.ctrl, 1'b0};
      wr_en <= 1'b0;
   endtask : stop
endmodule : txcf_partner
`default_nettype wire

// File: dv/txcf_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
module txcf_core_bench;
   import txcf_pkg::*;
   logic clk = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [WB_ADR_W-1:0] wb_adr_i = '0;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = '0, wb_dat_o;
   logic wb_ack_o, wr_en, rd_en = 1'b0, frame_rd = 1'b0, rd_valid, irq;
   txcf_word_s wr_word, rd_word, w_now;
   txcf_flags_s flags;
   txcf_word_s exp_q[$];
   logic [31:0] reg_q[$];
   int mismatches = 0, compares = 0, seed_v;
   txcf_core u_dut (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wr_word(wr_word), .wr_en(wr_en),
      .rd_en(rd_en), .frame_rd(frame_rd), .rd_word(rd_word), .rd_valid(rd_valid),
      .flags(flags), .irq(irq));
   txcf_partner u_part (.clk(clk), .wr_word(wr_word), .wr_en(wr_en));
   initial forever #20 clk = ~clk;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [72:0] seen, input logic [72:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      if (!we) reg_q.push_back(d);
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   task automatic put(input int n, input logic g, input bit keep);
      txcf_word_s w;
      for (int i = 0; i < n; i++) begin
         w = {$urandom, $urandom, 8'($urandom), 1'b1};
         if (keep) exp_q.push_back(w);
         u_part.send(w, g);
      end
   endtask : put
   task automatic rd(input int n, input logic fr);
      repeat (n) begin
         @(posedge clk);
         rd_en <= !fr;
         frame_rd <= fr;
      end
      @(posedge clk);
      rd_en <= 1'b0;
      frame_rd <= 1'b0;
   endtask : rd
   task automatic end_of_test();
      $display("mismatches=%0d compares=%0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   // ----------------------------------------
   // result watcher
   // ----------------------------------------
   always @(posedge clk) begin
      if (rd_valid === 1'b1) begin
         w_now = exp_q.size() ? exp_q.pop_front() : ~rd_word;
         check(rd_word, w_now);
      end
      if (wb_ack_o === 1'b1 && !wb_we_i) check(73'(wb_dat_o), 73'(reg_q.pop_front()));
   end
   initial begin
      #(40 * 3000);
      mismatches++;
      end_of_test();
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      seed_v = $urandom(32'h360A);
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      wb(0, 5'h00, 32'h0);
      wb(0, 5'h04, 32'h418);
      wb(0, 5'h08, 32'h5);
      wb(0, 5'h18, 32'h0);
      // basic: threshold boundaries 31 and 0, fill until refused, drain
      wb(1, 5'h00, 32'h3);
      wb(1, 5'h04, 32'h1F);
      wb(1, 5'h10, 32'hF);
      put(32, 1, 1);
      put(1, 1, 0);
      u_part.stop();
      wb(0, 5'h08, 32'hA);
      wb(0, 5'h14, 32'h20);
      wb(0, 5'h0C, 32'hD);
      check(73'(irq), 73'h1);
      wb(1, 5'h0C, 32'hF);
      wb(0, 5'h0C, 32'h0);
      rd(33, 0);
      wb(0, 5'h0C, 32'hA);
      wb(1, 5'h10, 32'h0);
      check(73'(irq), 73'h0);
      wb(1, 5'h0C, 32'hF);
      // interlaken: plain reads ignored, frame reads drain
      wb(1, 5'h00, 32'h2);
      put(3, 1, 1);
      u_part.stop();
      rd(3, 0);
      wb(0, 5'h14, 32'h3);
      rd(3, 1);
      // phase: valid alone writes
      wb(1, 5'h00, 32'h0);
      put(2, 0, 1);
      u_part.stop();
      wb(0, 5'h14, 32'h2);
      rd(2, 0);
      // register: bypass, one stage
      wb(1, 5'h00, 32'h1);
      wb(0, 5'h08, 32'h5);
      put(4, 0, 1);
      u_part.stop();
      repeat (4) @(posedge clk);
      check(73'(exp_q.size()), 73'h0);
      end_of_test();
   end
endmodule : txcf_core_bench
`default_nettype wire
